// file: hw/pfr_cfg.svh
`ifndef PFR_CFG_SVH
`define PFR_CFG_SVH
// Behaviour
// - first-capacitor code in bits 2..0, reset zero, value is 5 + 50*code pF.
// - third-resistor code in bits 6..0, reset zero, table gives ohms.
// - third-capacitor code in bits 2..0, reset zero, value is 5*code pF.
// - closed-loop settle select bits 3..2, 150/300/500/2000 us, reset code 2.
// - oscillator settle select bits 1..0, 20/400/4000/10000 us, reset code 1.
// - read-only stored check byte from nonvolatile memory, zero until loaded.
// - program-cycle counter increments after each erase/program, stored back to memory.
// - counter reloads after reset, after commit, after each erase/program cycle.
// - counter saturates at 255.
// - mismatch flag set when computed check differs from stored check byte.
// - memory copied into registers after reset and on commit request.
`define PFR_ADDR_CAP1 8'h25
`define PFR_ADDR_RES3 8'h26
`define PFR_ADDR_CAP3 8'h27
`define PFR_ADDR_CAL 8'h2A
`define PFR_ADDR_CHK 8'h2F
`define PFR_ADDR_CNT 8'h30
`define PFR_CAP1_MASK 8'h07
`define PFR_RES3_MASK 8'h7F
`define PFR_CAP3_MASK 8'h07
`define PFR_CAL_MASK 8'h0F
`define PFR_CAL_RESET 8'h09
`define PFR_CNT_MAX 8'hFF
`define PFR_CLK_MHZ 25
`define PFR_CL_US0 150
`define PFR_CL_US1 300
`define PFR_CL_US2 500
`define PFR_CL_US3 2000
`define PFR_OS_US0 20
`define PFR_OS_US1 400
`define PFR_OS_US2 4000
`define PFR_OS_US3 10000
`endif

// file: hw/pfr_pkg.sv
package pfr_pkg;
    // register access port bundle
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pfr_bus_s;
    // nonvolatile memory side events
    typedef struct packed {
        logic load;
        logic [7:0] chk;
        logic [7:0] calc_chk;
        logic [7:0] cnt;
        logic [7:0] cap1;
        logic [7:0] res3;
        logic [7:0] cap3;
        logic [7:0] cal;
        logic prog_done;
    } pfr_nvm_s;
    typedef enum logic [1:0] {
        PFR_IDLE = 2'b00,
        PFR_CL_WAIT = 2'b01,
        PFR_OS_WAIT = 2'b10
    } pfr_state_e;
    typedef logic [24:0] pfr_cnt_t;
endpackage

// file: hw/pfr_regs.sv
`timescale 1ns/1ps
`include "pfr_cfg.svh"
module pfr_regs
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire pfr_pkg::pfr_bus_s bus_i,
    input wire pfr_pkg::pfr_nvm_s nvm_i,
    input wire logic cal_start_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [2:0] loop_cap1_code_o,
    output logic [6:0] loop_res3_code_o,
    output logic [2:0] loop_cap3_code_o,
    output logic [3:0] calibration_wait_ctrl_o,
    output logic check_mismatch_flag_o,
    output logic [7:0] cnt_store_o,
    output logic cnt_store_vld_o,
    output logic cal_busy_o,
    output logic cal_done_o
);
    import pfr_pkg::*;
    typedef struct packed {
        logic [7:0] cap1;
        logic [7:0] res3;
        logic [7:0] cap3;
        logic [7:0] cal;
        logic [7:0] chk;
        logic [7:0] cnt;
        logic mism;
        logic [7:0] rdata;
        logic rvalid;
        logic [7:0] store;
        logic store_vld;
        logic busy;
        logic done;
    } pfr_regs_s;
    pfr_regs_s q, next_q;
    logic tmr_busy;
    logic tmr_done;
    // read mux, reserved bits come back zero
    function automatic logic [7:0] rd_mux(input pfr_regs_s s, input logic [7:0] a);
        unique case (a)
            `PFR_ADDR_CAP1: rd_mux = s.cap1 & `PFR_CAP1_MASK;
            `PFR_ADDR_RES3: rd_mux = s.res3 & `PFR_RES3_MASK;
            `PFR_ADDR_CAP3: rd_mux = s.cap3 & `PFR_CAP3_MASK;
            `PFR_ADDR_CAL: rd_mux = s.cal & `PFR_CAL_MASK;
            `PFR_ADDR_CHK: rd_mux = s.chk;
            `PFR_ADDR_CNT: rd_mux = s.cnt;
            default: rd_mux = 8'h00;
        endcase
    endfunction
    pfr_settle_timer u_tmr
    (
        .clk_sys_i(clk_sys_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .start_i(cal_start_i),
        .cl_sel_i(q.cal[3:2]),
        .os_sel_i(q.cal[1:0]),
        .busy_o(tmr_busy),
        .done_o(tmr_done)
    );
    // next-state: host write, then program event, then memory load
    always_comb
    begin
        next_q = q;
        next_q.rvalid = bus_i.rd;
        next_q.rdata = bus_i.rd ? rd_mux(q, bus_i.addr) : 8'h00;
        next_q.store_vld = 1'b0;
        next_q.busy = tmr_busy;
        next_q.done = tmr_done;
        if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                `PFR_ADDR_CAP1: next_q.cap1 = bus_i.wdata & `PFR_CAP1_MASK;
                `PFR_ADDR_RES3: next_q.res3 = bus_i.wdata & `PFR_RES3_MASK;
                `PFR_ADDR_CAP3: next_q.cap3 = bus_i.wdata & `PFR_CAP3_MASK;
                `PFR_ADDR_CAL: next_q.cal = bus_i.wdata & `PFR_CAL_MASK;
                default: next_q.cal = next_q.cal; // read-only and unmapped ignored
            endcase
        end
        // program done: bump count, stored back and reloaded as written
        if (nvm_i.prog_done)
        begin
            next_q.store = (nvm_i.cnt == `PFR_CNT_MAX) ? nvm_i.cnt : nvm_i.cnt + 8'h01;
            next_q.store_vld = 1'b1;
            next_q.cnt = next_q.store;
        end
        // memory-to-register copy, reset or commit, wins over host write
        if (nvm_i.load)
        begin
            next_q.cap1 = nvm_i.cap1 & `PFR_CAP1_MASK;
            next_q.res3 = nvm_i.res3 & `PFR_RES3_MASK;
            next_q.cap3 = nvm_i.cap3 & `PFR_CAP3_MASK;
            next_q.cal = nvm_i.cal & `PFR_CAL_MASK;
            next_q.chk = nvm_i.chk;
            next_q.cnt = nvm_i.cnt;
            next_q.mism = (nvm_i.calc_chk != nvm_i.chk);
        end
    end
    // zero-until-loaded reset except cal at code 9; memory copy follows on load
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            q <= '{cap1: 8'h00, res3: 8'h00, cap3: 8'h00, cal: `PFR_CAL_RESET, chk: 8'h00,
                   cnt: 8'h00, mism: 1'b0, rdata: 8'h00, rvalid: 1'b0, store: 8'h00,
                   store_vld: 1'b0, busy: 1'b0, done: 1'b0};
        else if (ce_i)
            q <= next_q;
    end
    assign rdata_o = q.rdata;
    assign rvalid_o = q.rvalid;
    assign loop_cap1_code_o = q.cap1[2:0];
    assign loop_res3_code_o = q.res3[6:0];
    assign loop_cap3_code_o = q.cap3[2:0];
    assign calibration_wait_ctrl_o = q.cal[3:0];
    assign check_mismatch_flag_o = q.mism;
    assign cnt_store_o = q.store;
    assign cnt_store_vld_o = q.store_vld;
    assign cal_busy_o = q.busy;
    assign cal_done_o = q.done;

    a_cnt_saturate: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && nvm_i.prog_done && !nvm_i.load && nvm_i.cnt == 8'hFF |=> q.cnt == 8'hFF)
        else $error("counter passed saturation");
    a_cnt_incr: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && nvm_i.prog_done && !nvm_i.load && nvm_i.cnt != 8'hFF |=> q.cnt == $past(nvm_i.cnt) + 8'h01)
        else $error("counter did not increment");
    a_store_pulse: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && nvm_i.prog_done |=> cnt_store_vld_o && cnt_store_o == q.cnt || $past(nvm_i.load))
        else $error("count not stored back");
    a_load_copy: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && nvm_i.load |=> q.chk == $past(nvm_i.chk) && q.cnt == $past(nvm_i.cnt))
        else $error("memory copy missing");
    a_mism_flag: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && nvm_i.load |=> check_mismatch_flag_o == ($past(nvm_i.calc_chk) != $past(nvm_i.chk)))
        else $error("mismatch flag wrong");
    a_rsvd_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        rvalid_o && $past(bus_i.addr) == 8'h25 |-> rdata_o[7:3] == 5'h00)
        else $error("reserved bits nonzero");
    a_cap1_write: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && bus_i.wr && bus_i.addr == 8'h25 && !nvm_i.load |=> loop_cap1_code_o == $past(bus_i.wdata[2:0]))
        else $error("cap1 write lost");
    a_res3_write: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && bus_i.wr && bus_i.addr == 8'h26 && !nvm_i.load |=> loop_res3_code_o == $past(bus_i.wdata[6:0]))
        else $error("res3 write lost");
    a_cap3_write: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        ce_i && bus_i.wr && bus_i.addr == 8'h27 && !nvm_i.load |=> loop_cap3_code_o == $past(bus_i.wdata[2:0]))
        else $error("cap3 write lost");
    a_cal_reset: assert property (@(posedge clk_sys_i)
        srst_i |=> calibration_wait_ctrl_o == 4'h9)
        else $error("settle selectors reset wrong");
endmodule

// file: hw/pfr_settle_timer.sv
`timescale 1ns/1ps
`include "pfr_cfg.svh"
module pfr_settle_timer
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic start_i,
    input wire logic [1:0] cl_sel_i,
    input wire logic [1:0] os_sel_i,
    output logic busy_o,
    output logic done_o
);
    import pfr_pkg::*;
    typedef struct packed {
        pfr_state_e st;
        pfr_cnt_t cnt;
        logic busy;
        logic done;
    } pfr_tmr_s;
    pfr_tmr_s q, next_q;
    // microsecond figure to cycles at the system clock
    function automatic pfr_cnt_t us_to_cyc(input int us);
        us_to_cyc = pfr_cnt_t'(us * `PFR_CLK_MHZ);
    endfunction
    function automatic pfr_cnt_t cl_cyc(input logic [1:0] s);
        unique case (s)
            2'h0: cl_cyc = us_to_cyc(`PFR_CL_US0);
            2'h1: cl_cyc = us_to_cyc(`PFR_CL_US1);
            2'h2: cl_cyc = us_to_cyc(`PFR_CL_US2);
            2'h3: cl_cyc = us_to_cyc(`PFR_CL_US3);
        endcase
    endfunction
    function automatic pfr_cnt_t os_cyc(input logic [1:0] s);
        unique case (s)
            2'h0: os_cyc = us_to_cyc(`PFR_OS_US0);
            2'h1: os_cyc = us_to_cyc(`PFR_OS_US1);
            2'h2: os_cyc = us_to_cyc(`PFR_OS_US2);
            2'h3: os_cyc = us_to_cyc(`PFR_OS_US3);
        endcase
    endfunction
    // oscillator wait first, then closed-loop wait
    always_comb
    begin
        next_q = q;
        next_q.done = 1'b0;
        unique case (q.st)
            PFR_IDLE:
            begin
                if (start_i)
                begin
                    next_q.st = PFR_OS_WAIT;
                    next_q.cnt = os_cyc(os_sel_i) - pfr_cnt_t'(1);
                    next_q.busy = 1'b1;
                end
            end
            PFR_OS_WAIT:
            begin
                if (q.cnt == '0)
                begin
                    next_q.st = PFR_CL_WAIT;
                    next_q.cnt = cl_cyc(cl_sel_i) - pfr_cnt_t'(1);
                end
                else
                    next_q.cnt = q.cnt - pfr_cnt_t'(1);
            end
            PFR_CL_WAIT:
            begin
                if (q.cnt == '0)
                begin
                    next_q.st = PFR_IDLE;
                    next_q.busy = 1'b0;
                    next_q.done = 1'b1;
                end
                else
                    next_q.cnt = q.cnt - pfr_cnt_t'(1);
            end
            default: next_q.st = PFR_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
            q <= '{st: PFR_IDLE, cnt: '0, busy: 1'b0, done: 1'b0};
        else if (ce_i)
            q <= next_q;
    end
    assign busy_o = q.busy;
    assign done_o = q.done;
endmodule

// file: tb/pfr_nvm_model.sv
`timescale 1ns/1ps
module pfr_nvm_model
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic commit_i,
    input wire logic prog_i,
    input wire pfr_pkg::pfr_nvm_s img_i,
    input wire logic [7:0] cnt_store_i,
    input wire logic cnt_store_vld_i,
    output pfr_pkg::pfr_nvm_s nvm_o
);
    import pfr_pkg::*;
    logic after_rst;
    logic ld;
    logic pd;
    logic [7:0] mem_cnt;
    pfr_nvm_s full;
    // copy pulse after reset and on commit; count lives in memory
    always_ff @(posedge clk_sys_i)
    begin
        ld <= !srst_i && (after_rst || commit_i);
        after_rst <= srst_i;
        pd <= !srst_i && prog_i;
        if (srst_i)
        begin
            mem_cnt <= img_i.cnt;
        end
        else if (cnt_store_vld_i)
        begin
            mem_cnt <= cnt_store_i;
        end
    end
    // lines show the inverse outside a pulse, so a stale sample cannot pass
    always_comb
    begin
        full = img_i;
        full.cnt = mem_cnt;
        nvm_o = (ld || pd) ? full : ~full;
        nvm_o.load = ld;
        nvm_o.prog_done = pd;
    end
endmodule

// file: tb/test_pll_filter_and_nvm_status_regs.sv
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
    $display("unexpected %0t: got %h want %h", $time, g, e); end end
module test_pll_filter_and_nvm_status_regs;
    import pfr_pkg::*;
    logic clk_sys_i = 0;
    logic srst_i = 1;
    logic cal_start = 0;
    logic commit = 0;
    logic prog = 0;
    logic ce = 1;
    pfr_bus_s bus = '0;
    pfr_nvm_s img;
    pfr_nvm_s nvm;
    logic [7:0] rdata, cnt_store, a, d, v;
    logic [7:0] sh [256];
    logic [7:0] addrs [7] = '{8'h25, 8'h26, 8'h27, 8'h2A, 8'h2F, 8'h30, 8'h31};
    logic rvalid, cnt_vld, flag, done, busy;
    logic [7:0] cw;
    logic [2:0] cap1, cap3;
    logic [6:0] res3;
    logic [3:0] cal;
    int bad_count = 0;
    int n_tests = 0;
    int n;
    int exp_n;
    // free-running system clock
    always #20 clk_sys_i = ~clk_sys_i;
    pfr_regs i_dut (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .ce_i(ce), .bus_i(bus), .nvm_i(nvm),
        .cal_start_i(cal_start), .rdata_o(rdata), .rvalid_o(rvalid), .loop_cap1_code_o(cap1),
        .loop_res3_code_o(res3), .loop_cap3_code_o(cap3), .calibration_wait_ctrl_o(cal),
        .check_mismatch_flag_o(flag), .cnt_store_o(cnt_store), .cnt_store_vld_o(cnt_vld),
        .cal_busy_o(busy), .cal_done_o(done));
    pfr_nvm_model i_nvm (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .commit_i(commit), .prog_i(prog),
        .img_i(img), .cnt_store_i(cnt_store), .cnt_store_vld_i(cnt_vld), .nvm_o(nvm));
    task automatic summarize;
        if (bad_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cyc;
        @(posedge clk_sys_i);
        #1;
    endtask
    // idle cycle after each access keeps strobes from being driven twice at once
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        bus = '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: dt};
        cyc();
        bus = '0;
        cyc();
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] q);
        bus = '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 8'h00};
        cyc();
        bus = '0;
        q = (rvalid === 1'b1) ? rdata : 8'hXX;
        cyc();
    endtask
    function automatic logic [7:0] msk(input logic [7:0] ad);
        case (ad)
            8'h25, 8'h27: return 8'h07;
            8'h26: return 8'h7F;
            8'h2A: return 8'h0F;
            default: return 8'h00;
        endcase
    endfunction
    // settle span in cycles: oscillator wait, then closed-loop wait, plus the output register
    function automatic int settle_cyc(input logic [3:0] c);
        int os_us [4] = '{20, 400, 4000, 10000};
        int cl_us [4] = '{150, 300, 500, 2000};
        return (os_us[c[1:0]] + cl_us[c[3:2]]) * 25 + 1;
    endfunction
    // expected register image after a copy from memory
    task automatic load_img;
        sh = '{default: 8'h00};
        sh[8'h25] = img.cap1 & msk(8'h25);
        sh[8'h26] = img.res3 & msk(8'h26);
        sh[8'h27] = img.cap3 & msk(8'h27);
        sh[8'h2A] = img.cal & msk(8'h2A);
        sh[8'h2F] = img.chk;
        sh[8'h30] = i_nvm.img_i.cnt;
    endtask
    task automatic outs;
        `CHK(cap1, sh[8'h25][2:0])
        `CHK(res3, sh[8'h26][6:0])
        `CHK(cap3, sh[8'h27][2:0])
        `CHK(cal, sh[8'h2A][3:0])
    endtask
    initial
    begin
        void'($urandom(48));
        img = '{load: 0, chk: 8'hA5, calc_chk: 8'h5A, cnt: 8'hFE, cap1: 8'hFD, res3: 8'h94,
            cap3: 8'h0B, cal: 8'hF6, prog_done: 0};
        repeat (4) @(posedge clk_sys_i);
        #1;
        `CHK({cap1, res3, cap3}, 13'h0000)
        `CHK(cal, 4'h9)
        `CHK(flag, 1'b0)
        srst_i = 0;
        // check byte read in the first cycle, before the memory copy lands
        rd(8'h2F, v);
        `CHK(v, 8'h00)
        cyc();
        load_img();
        outs();
        `CHK(flag, 1'b1)
        // random accesses, read-only and unmapped places among them
        for (n = 0; n < 30; n++)
        begin
            a = addrs[n < 7 ? n : $urandom_range(6)];
            d = 8'($urandom);
            if (n >= 7)
                wr(a, d);
            if (n >= 7 && msk(a) != 8'h00)
                sh[a] = d & msk(a);
            outs();
            rd(a, v);
            `CHK(v, sh[a])
        end
        // commit with a matching check clears the flag and reloads
        img.calc_chk = img.chk;
        img.cap1 = 8'h02;
        commit = 1;
        cyc();
        commit = 0;
        repeat (3) cyc();
        load_img();
        outs();
        `CHK(flag, 1'b0)
        // clock enable low: a write strobe is not taken and state holds
        ce = 0;
        wr(8'h25, 8'h05);
        ce = 1;
        outs();
        // two program cycles from 254: second one must saturate
        for (n = 0; n < 2; n++)
        begin
            prog = 1;
            cyc();
            prog = 0;
            repeat (3) if (cnt_vld !== 1'b1) cyc();
            `CHK(cnt_store, 8'hFF)
            cyc();
            rd(8'h30, v);
            `CHK(v, 8'hFF)
        end
        // shortest codes, then closed-loop code 1; longer codes would blow the run budget
        for (int k = 0; k < 2; k++)
        begin
            cw = k ? 8'h04 : 8'h00;
            wr(8'h2A, cw);
            cal_start = 1;
            cyc();
            cal_start = 0;
            n = 0;
            exp_n = settle_cyc(cw[3:0]);
            while (done !== 1'b1 && n < exp_n + 50)
            begin
                if (n == 10)
                    `CHK(busy, 1'b1)
                cyc();
                n++;
            end
            `CHK(n >= exp_n - 2 && n <= exp_n + 5, 1'b1)
            `CHK(busy, 1'b0)
        end
        wr(8'h2A, 8'h09);
        summarize();
    end
    // watchdog well past the expected run length
    initial
    begin
        #(40 * 30000);
        bad_count++;
        summarize();
    end
endmodule
